// >>> verilog/pciu_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pciu_cfg.svh"

// Overview of operation
// [RL1] group 2 requests on unmasked pin 23..16 change
// [RL2] group 1 requests on unmasked pin 10..8 change
// [RL3] group 0 requests on unmasked pin 7..0 change
// [RL4] each group has its own vector
// [RL5] group 2 change sets flag bit 2
// [RL6] group 1 change sets flag bit 1
// [RL7] group 0 change sets flag bit 0
// [RL8] branch needs flag, group enable, global flag
// [RL9] vector service clears that group's flag
// [RL10] flags cleared by writing one
// [RL11] mask low enables pins 7..0
// [RL12] mask mid bits 2..0 enable pins 10..8
// [RL13] mask high enables pins 23..16
// [RL14] cleared mask bit blocks that pin
// [RL15] unused upper bits read zero
// [RL16] change detection independent of io clock; here the pins are sampled on clk
// [RL17] pins driven as outputs still fire
// [RL18] change is any level difference
// [RL19] hardware set beats software clear

module pciu_top
  import pciu_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`PCIU_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // pad levels, seen whatever the pin direction
  input  wire logic [`PCIU_LOW_PINS-1:0]  pin_low,
  input  wire logic [`PCIU_MID_PINS-1:0]  pin_mid,
  input  wire logic [`PCIU_HIGH_PINS-1:0] pin_high,
  // cpu side
  input  wire logic                       global_int_enable,
  input  wire logic                       vector_ack,
  input  wire logic [1:0]                 vector_ack_index,
  output logic                            irq_request,
  output logic      [1:0]                 irq_vector
);

  // ****************************************
  // pin sampling and change detection
  // ****************************************
  logic [`PCIU_LOW_PINS-1:0]  lvl_low;
  logic [`PCIU_MID_PINS-1:0]  lvl_mid;
  logic [`PCIU_HIGH_PINS-1:0] lvl_high;
  logic [`PCIU_LOW_PINS-1:0]  chg_low;
  logic [`PCIU_MID_PINS-1:0]  chg_mid;
  logic [`PCIU_HIGH_PINS-1:0] chg_high;

  // pads are read directly, so a pin the cpu drives still toggles
  // its own detector
  pciu_sync #(.WIDTH(`PCIU_LOW_PINS)) u_sync_low ( // [RL17]
    .clk       (clk),
    .rst       (rst),
    .pin_async (pin_low),
    .level     (lvl_low),
    .change    (chg_low)
  );

  pciu_sync #(.WIDTH(`PCIU_MID_PINS)) u_sync_mid (
    .clk       (clk),
    .rst       (rst),
    .pin_async (pin_mid),
    .level     (lvl_mid),
    .change    (chg_mid)
  );

  pciu_sync #(.WIDTH(`PCIU_HIGH_PINS)) u_sync_high (
    .clk       (clk),
    .rst       (rst),
    .pin_async (pin_high),
    .level     (lvl_high),
    .change    (chg_high)
  );

  // ****************************************
  // register state
  // ****************************************
  // narrow registers store only their live bits; the rest read zero
  pciu_grp_t                  enable_reg;
  pciu_grp_t                  enable_next;
  pciu_grp_t                  flags_reg;
  pciu_grp_t                  flags_next;
  logic [`PCIU_LOW_PINS-1:0]  mask_low_reg;
  logic [`PCIU_LOW_PINS-1:0]  mask_low_next;
  logic [`PCIU_MID_PINS-1:0]  mask_mid_reg;
  logic [`PCIU_MID_PINS-1:0]  mask_mid_next;
  logic [`PCIU_HIGH_PINS-1:0] mask_high_reg;
  logic [`PCIU_HIGH_PINS-1:0] mask_high_next;

  // ****************************************
  // apb decode
  // ****************************************
  logic       pready_reg;
  logic       pready_next;
  logic       pslverr_reg;
  logic       pslverr_next;
  pciu_word_t prdata_reg;
  pciu_word_t prdata_next;
  logic       wr_done;
  logic       lane0;

  // one list of mapped words, shared by the error reply
  function automatic logic addr_mapped(
    input logic [`PCIU_ADDR_W-1:0] a
  );
    case (a)
      `PCIU_OFF_ENABLE,
      `PCIU_OFF_FLAGS,
      `PCIU_OFF_MASK_LOW,
      `PCIU_OFF_MASK_MID,
      `PCIU_OFF_MASK_HIGH,
      `PCIU_OFF_PIN_LEVEL: addr_mapped = 1'b1;
      default:             addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // one wait state so that read data leaves a flip-flop; a write
  // lands only on the edge that also completes the access, so a
  // slow master can never write the same word twice
  assign wr_done = psel && penable && pwrite && pready_reg;
  // every writable register fits in the lowest byte lane, so only that
  // strobe matters; the other lanes are ignored without an error
  assign lane0   = pstrb[0];

  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = '0;
    if (pready_next) begin
      // unmapped word: error reply, write dropped, read data zero
      pslverr_next = !addr_mapped(paddr);
      if (!pwrite) begin
        // narrow registers padded so upper bits read zero
        case (paddr)
          `PCIU_OFF_ENABLE:    prdata_next = {29'h0, enable_reg}; // [RL15]
          `PCIU_OFF_FLAGS:     prdata_next = {29'h0, flags_reg}; // [RL15]
          `PCIU_OFF_MASK_LOW:  prdata_next = {24'h0, mask_low_reg};
          `PCIU_OFF_MASK_MID:  prdata_next = {29'h0, mask_mid_reg}; // [RL15]
          `PCIU_OFF_MASK_HIGH: prdata_next = {24'h0, mask_high_reg};
          // live pad levels, for software that polls instead of
          // taking the interrupt
          `PCIU_OFF_PIN_LEVEL: prdata_next = {13'h0, lvl_high, lvl_mid,
                                              lvl_low};
          default:             prdata_next = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;

  // ****************************************
  // control and mask registers
  // ****************************************
  always_comb begin
    enable_next    = enable_reg;
    mask_low_next  = mask_low_reg;
    mask_mid_next  = mask_mid_reg;
    mask_high_next = mask_high_reg;
    if (wr_done && lane0) begin
      case (paddr)
        `PCIU_OFF_ENABLE:    enable_next    = pwdata[2:0];
        `PCIU_OFF_MASK_LOW:  mask_low_next  = pwdata[7:0]; // [RL11]
        `PCIU_OFF_MASK_MID:  mask_mid_next  = pwdata[2:0]; // [RL12]
        `PCIU_OFF_MASK_HIGH: mask_high_next = pwdata[7:0]; // [RL13]
        // flags are cleared below; the level readback ignores writes
        default:             enable_next    = enable_reg;
      endcase
    end
  end

  // ****************************************
  // group events and flags
  // ****************************************
  pciu_grp_t grp_event;
  pciu_grp_t clr_sw;
  pciu_grp_t clr_ack;

  // a pin counts only with its own mask bit and its group enable
  always_comb begin
    grp_event[`PCIU_BIT_GROUP0] = enable_reg[`PCIU_BIT_GROUP0] &&
                                  |(chg_low & mask_low_reg); // [RL3] [RL11] [RL14]
    grp_event[`PCIU_BIT_GROUP1] = enable_reg[`PCIU_BIT_GROUP1] &&
                                  |(chg_mid & mask_mid_reg); // [RL2] [RL12] [RL14]
    grp_event[`PCIU_BIT_GROUP2] = enable_reg[`PCIU_BIT_GROUP2] &&
                                  |(chg_high & mask_high_reg); // [RL1] [RL13] [RL14]
  end

  always_comb begin
    clr_sw  = '0;
    clr_ack = '0;
    if (wr_done && lane0 && paddr == `PCIU_OFF_FLAGS) begin
      clr_sw = pwdata[2:0]; // [RL10]
    end
    // index 3 names no group; dropping it keeps a stray acknowledge
    // from clearing a flag that was never taken
    if (vector_ack && vector_ack_index < 2'h3) begin
      clr_ack[vector_ack_index] = 1'b1; // [RL9]
    end
  end

  // a flag set while the global flag is low stays pending, so the
  // request follows as soon as the cpu lets interrupts through
  genvar g;
  generate
    for (g = 0; g < `PCIU_GROUPS; g++) begin : g_flag
      // set term last so a same-cycle event survives the clear
      always_comb begin
        flags_next[g] = (flags_reg[g] && !clr_sw[g] && !clr_ack[g]) ||
                        grp_event[g]; // [RL5] [RL6] [RL7] [RL19]
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg    <= `PCIU_RST_ENABLE;
      flags_reg     <= `PCIU_RST_FLAGS;
      mask_low_reg  <= `PCIU_RST_MASK_LOW;
      mask_mid_reg  <= `PCIU_RST_MASK_MID;
      mask_high_reg <= `PCIU_RST_MASK_HIGH;
    end else begin
      enable_reg    <= enable_next;
      flags_reg     <= flags_next;
      mask_low_reg  <= mask_low_next;
      mask_mid_reg  <= mask_mid_next;
      mask_high_reg <= mask_high_next;
    end
  end

  // ****************************************
  // vector request to the cpu
  // ****************************************
  pciu_grp_t pending_next;
  logic      arb_valid;
  pciu_vec_t arb_vector;
  logic      irq_request_reg;
  logic      irq_request_next;
  logic [1:0] irq_vector_reg;
  logic [1:0] irq_vector_next;

  // computed from next state so the request drops with the flag;
  // a registered flag would hold the request one cycle past the
  // acknowledge, and the cpu could enter the same vector twice
  assign pending_next = flags_next & enable_next; // [RL8]

  // fixed priority: one vector at a time, the others keep waiting
  pciu_arb u_arb (
    .pending (pending_next),
    .valid   (arb_valid),
    .vector  (arb_vector)
  );

  // registered so the cpu sees request and vector change together
  always_comb begin
    irq_request_next = arb_valid && global_int_enable; // [RL8]
    irq_vector_next  = irq_request_next ? arb_vector : 2'h0; // [RL4]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_request_reg <= 1'b0;
      irq_vector_reg  <= 2'h0;
    end else begin
      irq_request_reg <= irq_request_next;
      irq_vector_reg  <= irq_vector_next;
    end
  end

  // pins are sampled on clk; a sleeping system needs its own wake
  // path from the raw pads, outside this block
  assign irq_request = irq_request_reg; // [RL16]
  assign irq_vector  = irq_vector_reg;

endmodule : pciu_top

// >>> include/pciu_cfg.svh
`ifndef PCIU_CFG_SVH
`define PCIU_CFG_SVH

// ****************************************
// register byte offsets on the apb
// ****************************************
`define PCIU_ADDR_W        12
`define PCIU_OFF_ENABLE    12'h000
`define PCIU_OFF_FLAGS     12'h004
`define PCIU_OFF_MASK_LOW  12'h008
`define PCIU_OFF_MASK_MID  12'h00c
`define PCIU_OFF_MASK_HIGH 12'h010
`define PCIU_OFF_PIN_LEVEL 12'h014

// ****************************************
// field widths and positions
// ****************************************
`define PCIU_GROUPS        3
`define PCIU_LOW_PINS      8
`define PCIU_MID_PINS      3
`define PCIU_HIGH_PINS     8
`define PCIU_BIT_GROUP0    0
`define PCIU_BIT_GROUP1    1
`define PCIU_BIT_GROUP2    2

// ****************************************
// reset values
// ****************************************
`define PCIU_RST_ENABLE    3'h0
`define PCIU_RST_FLAGS     3'h0
`define PCIU_RST_MASK_LOW  8'h00
`define PCIU_RST_MASK_MID  3'h0
`define PCIU_RST_MASK_HIGH 8'h00

// ****************************************
// timing counts
// ****************************************
// edges after reset before change detection is trusted
`define PCIU_PRIME_CYCLES  2'h3

`endif

// >>> include/pciu_pkg.sv
package pciu_pkg;

  typedef logic [7:0]  pciu_byte_t;
  typedef logic [31:0] pciu_word_t;
  typedef logic [2:0]  pciu_grp_t;

  // vector index of the three groups, group 0 first
  typedef enum logic [1:0] {
    PCIU_VEC_GROUP0,
    PCIU_VEC_GROUP1,
    PCIU_VEC_GROUP2,
    PCIU_VEC_NONE
  } pciu_vec_t;

endpackage : pciu_pkg

// >>> verilog/pciu_sync.sv
`timescale 1ns/1ps
`include "pciu_cfg.svh"

module pciu_sync
  import pciu_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw pins
  input  wire logic [WIDTH-1:0] pin_async,
  // synchronised level and change pulses
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] change
);

  // ****************************************
  // two-stage synchroniser plus history
  // ****************************************
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [1:0]       prime_reg;
  logic [1:0]       prime_next;

  always_comb begin
    prime_next = prime_reg;
    if (prime_reg != `PCIU_PRIME_CYCLES) begin
      prime_next = prime_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg  <= '0;
      sync_reg  <= '0;
      prev_reg  <= '0;
      prime_reg <= 2'h0;
    end else begin
      meta_reg  <= pin_async;
      sync_reg  <= meta_reg;
      prev_reg  <= sync_reg;
      prime_reg <= prime_next;
    end
  end

  // either direction counts; held off until history is filled so a
  // strapped-high pin does not look like a change after reset
  assign level  = sync_reg;
  assign change = (prime_reg == `PCIU_PRIME_CYCLES) ?
                  (sync_reg ^ prev_reg) : '0; // [RL18]

endmodule : pciu_sync

// >>> verilog/pciu_arb.sv
`timescale 1ns/1ps
`include "pciu_cfg.svh"

module pciu_arb
  import pciu_pkg::*;
(
  // pending groups, flag and enable both set
  input  wire logic      [`PCIU_GROUPS-1:0] pending,
  // chosen vector
  output logic                              valid,
  output pciu_vec_t                         vector
);

  // ****************************************
  // fixed priority, lowest group first
  // ****************************************
  always_comb begin
    valid  = |pending;
    vector = PCIU_VEC_NONE;
    if (pending[`PCIU_BIT_GROUP0]) begin
      vector = PCIU_VEC_GROUP0;
    end else if (pending[`PCIU_BIT_GROUP1]) begin
      vector = PCIU_VEC_GROUP1;
    end else if (pending[`PCIU_BIT_GROUP2]) begin
      vector = PCIU_VEC_GROUP2;
    end
  end

endmodule : pciu_arb

// >>> tb/pciu_pins_model.sv
`timescale 1ns/1ps

module pciu_pins_model (
  // clock
  input  wire logic        clk,
  // toggle requests, bit 0 is pin 0, bits 18..11 pins 23..16
  input  wire logic [18:0] flip,
  // pad levels
  output logic      [7:0]  pin_low,
  output logic      [2:0]  pin_mid,
  output logic      [7:0]  pin_high
);
  logic [18:0] lvl = 19'h0;

  // board flops, so a pad moves just after an edge, never mid-cycle
  always @(posedge clk) lvl <= lvl ^ flip;
  assign {pin_high, pin_mid, pin_low} = lvl;
endmodule : pciu_pins_model

// >>> tb/pciu_assertions.sv
`timescale 1ns/1ps
`include "pciu_cfg.svh"

module pciu_chk (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // cpu side
  input  wire logic        global_int_enable,
  input  wire logic        vector_ack,
  input  wire logic [1:0]  vector_ack_index,
  input  wire logic        irq_request,
  input  wire logic [1:0]  irq_vector
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence acc_start;
    psel && penable && !$past(penable);
  endsequence

  sequence narrow_rd;
    pready && !pwrite && (paddr == `PCIU_OFF_ENABLE ||
      paddr == `PCIU_OFF_FLAGS || paddr == `PCIU_OFF_MASK_MID);
  endsequence

  ready_one_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property (acc_start |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  rsvd_zero_a: assert property (narrow_rd |-> prdata[31:3] == 29'h0)
    else $error("upper bits not zero");
  bad_addr_a: assert property (pready && paddr > `PCIU_OFF_PIN_LEVEL
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  irq_gate_a: assert property (
    !global_int_enable [*2] |-> !irq_request)
    else $error("request with global flag low");
  vec_idle_a: assert property (!irq_request |-> irq_vector == 2'h0)
    else $error("vector not zero when idle");
  vec_range_a: assert property (irq_request |-> irq_vector != 2'h3)
    else $error("no such vector");
  ack_clear_a: assert property (vector_ack && irq_request &&
    vector_ack_index == irq_vector
    |=> !irq_request || irq_vector != $past(irq_vector))
    else $error("serviced flag still pending");
  irq_hold_a: assert property (irq_request && global_int_enable &&
    !vector_ack && !psel ##1 global_int_enable |-> irq_request)
    else $error("request dropped without clear");
endmodule : pciu_chk

bind pciu_top pciu_chk u_pciu_chk (
  .clk               (clk),
  .rst               (rst),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .global_int_enable (global_int_enable),
  .vector_ack        (vector_ack),
  .vector_ack_index  (vector_ack_index),
  .irq_request       (irq_request),
  .irq_vector        (irq_vector)
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "pciu_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [7:0]  pin_low, pin_high;
  logic [2:0]  pin_mid;
  logic [18:0] flip;
  logic        global_int_enable, vector_ack, irq_request;
  logic [1:0]  vector_ack_index, irq_vector;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          msk[3] = '{1, 9, 11};
  int          unm[3] = '{0, 8, 13};

  pciu_top u_pciu_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_low(pin_low), .pin_mid(pin_mid), .pin_high(pin_high),
    .global_int_enable(global_int_enable), .vector_ack(vector_ack),
    .vector_ack_index(vector_ack_index), .irq_request(irq_request),
    .irq_vector(irq_vector));
  pciu_pins_model u_pciu_pins_model (.clk(clk), .flip(flip),
    .pin_low(pin_low), .pin_mid(pin_mid), .pin_high(pin_high));

  // ****************
  // bus and pin tasks
  // ****************
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask : rd

  task automatic tog(input int i);
    @(posedge clk);
    flip <= 19'h1 << i;
    @(posedge clk);
    flip <= 19'h0;
    repeat (5) @(posedge clk);
  endtask : tog

  task automatic ack(input logic [1:0] g);
    @(posedge clk);
    vector_ack       <= 1'b1;
    vector_ack_index <= g;
    @(posedge clk);
    vector_ack       <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : ack

  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ****************
  // clock, watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is about 250 cycles; sixteen times that means a hang
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    end_sim;
  end

  // ****************
  // tests
  // ****************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, vector_ack} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    flip = 19'h0;
    vector_ack_index = 2'h0;
    global_int_enable = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
    wr(`PCIU_OFF_ENABLE, 32'hff);
    rd(`PCIU_OFF_ENABLE, 32'h7);
    wr(`PCIU_OFF_MASK_MID, 32'hfd);
    rd(`PCIU_OFF_MASK_MID, 32'h5);
    wr(`PCIU_OFF_MASK_LOW, 32'ha5);
    rd(`PCIU_OFF_MASK_LOW, 32'ha5);
    wr(`PCIU_OFF_MASK_HIGH, 32'h3c);
    rd(`PCIU_OFF_MASK_HIGH, 32'h3c);
    pstrb <= 4'h0;
    wr(`PCIU_OFF_MASK_LOW, 32'hff);
    pstrb <= 4'hf;
    rd(`PCIU_OFF_MASK_LOW, 32'ha5);
    xfer(12'h040, 1'b0, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    for (int g = 0; g < 3; g++) begin
      tog(msk[g]);
      rd(`PCIU_OFF_FLAGS, 32'h0);
      tog(unm[g]);
      `CHK(irq_request, 1'b1)
      `CHK(irq_vector, 2'(g))
      rd(`PCIU_OFF_FLAGS, 32'h1 << g);
      ack(2'(g));
      `CHK(irq_request, 1'b0)
      rd(`PCIU_OFF_FLAGS, 32'h0);
    end
    global_int_enable <= 1'b0;
    tog(0);
    `CHK(irq_request, 1'b0)
    rd(`PCIU_OFF_FLAGS, 32'h1);
    wr(`PCIU_OFF_FLAGS, 32'h6);
    rd(`PCIU_OFF_FLAGS, 32'h1);
    wr(`PCIU_OFF_FLAGS, 32'h1);
    rd(`PCIU_OFF_FLAGS, 32'h0);
    // clear lands on the very edge at which pin 2 sets the flag
    fork
      tog(2);
      begin
        @(posedge clk);
        wr(`PCIU_OFF_FLAGS, 32'h1);
      end
    join
    rd(`PCIU_OFF_FLAGS, 32'h1);
    tog(unm[2]);
    global_int_enable <= 1'b1;
    ack(2'h3);
    `CHK({irq_request, irq_vector}, 3'h4)
    rd(`PCIU_OFF_FLAGS, 32'h5);
    ack(2'h0);
    `CHK({irq_request, irq_vector}, 3'h6)
    ack(2'h2);
    `CHK(irq_request, 1'b0)
    wr(`PCIU_OFF_ENABLE, 32'h6);
    tog(0);
    rd(`PCIU_OFF_FLAGS, 32'h0);
    rd(`PCIU_OFF_PIN_LEVEL, {13'h0, pin_high, pin_mid, pin_low});
    end_sim;
  end
endmodule : tb_top
